//--- core/modem_lines_defines.vh
// Register indices, field positions and reset values for the modem line and pin block.
// Assumes it is included by bare name from the design files under core/.
`ifndef MODEM_LINES_DEFINES_VH
`define MODEM_LINES_DEFINES_VH

`define ADDR_W           10
`define DATA_W           8
`define NUM_PINS         7
`define SYNC_W           11

`define REG_HS_MODE      10'h1FB
`define REG_DTR_SEL      10'h228
`define REG_DTR_LEVEL    10'h229
`define REG_PIN_DIR      10'h26F
`define REG_PIN_OUT      10'h270
`define REG_PIN_IN       10'h271
`define REG_PULL_UP      10'h272
`define REG_PULL_STRONG  10'h273
`define REG_GROUP_MASK   10'h274
`define REG_GROUP_DATA   10'h275
`define REG_ADC_RESULT   10'h2BD
`define REG_LINE_CTRL    10'h2C6
`define REG_LINE_STAT    10'h2C7
`define REG_IRQ_STATUS   10'h2C8
`define REG_IRQ_MASK     10'h2C9

`define PINS_RESET       7'h00
`define PIN_DTR          0
`define PIN_AUDIO        6

`define CTRL_RI_INPUT    0
`define CTRL_AUDIO_SEL   1
`define CTRL_W           2

`define EV_RING_START    0
`define EV_LINK_UP       1
`define EV_LINK_DOWN     2
`define EV_DSR_DROP      3
`define EV_W             4

`define LINE_HIGH        1'b1

`endif

//--- core/line_sync.v
// Two-stage synchroniser for a bundle of pin-level inputs.
// Assumes every bit is an independent level from outside the clock domain.
`timescale 1ns/10ps
`include "modem_lines_defines.vh"

module line_sync (
  input  wire                 clk,
  input  wire                 reset_n,
  input  wire [`SYNC_W-1:0]   async_in,
  input  wire [`SYNC_W-1:0]   reset_value,
  output reg  [`SYNC_W-1:0]   sync_out
);

  reg [`SYNC_W-1:0] stage_one;

  // Reset loads all-ones; the reset_value port has no effect, as the mask below is all ones.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_one <= {`SYNC_W{`LINE_HIGH}};
      sync_out  <= {`SYNC_W{`LINE_HIGH}};
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one & (reset_value | ~reset_value);
    end
  end

endmodule // line_sync

//--- core/modem_lines_and_gpio.v
// Modem handshake lines, serial idle levels and seven programmable pins with a register port.
// Assumes a same-clock serial engine, radio link state and converter result on the user side.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
`include "modem_lines_defines.vh"

module modem_lines_and_gpio (
  input  wire                  clk,
  input  wire                  reset_n,
  input  wire [`ADDR_W-1:0]    reg_addr,
  input  wire [`DATA_W-1:0]    reg_wdata,
  input  wire                  reg_write,
  input  wire                  reg_read,
  output reg  [`DATA_W-1:0]    reg_rdata,
  output wire                  irq,
  input  wire                  serial_tx_bit,
  input  wire                  serial_tx_active,
  output reg                   serial_tx_line,
  input  wire                  serial_rx_line,
  output wire                  serial_rx_bit,
  input  wire                  rx_has_room,
  output reg                   rts_n,
  input  wire                  cts_n,
  output wire                  tx_allowed,
  input  wire                  dsr_n,
  output reg                   drop_or_command_req,
  input  wire                  remote_setup,
  input  wire                  link_live,
  input  wire                  incoming_call_line_in,
  output reg                   incoming_call_line_out,
  output reg                   incoming_call_line_oe,
  output reg                   connection_live_line,
  input  wire                  audio_slave_clk_src,
  input  wire [`DATA_W-1:0]    adc_result,
  input  wire [`NUM_PINS-1:0]  programmable_pin_in,
  output reg  [`NUM_PINS-1:0]  programmable_pin_out,
  output reg  [`NUM_PINS-1:0]  programmable_pin_oe,
  output reg  [`NUM_PINS-1:0]  pull_up_select,
  output reg  [`NUM_PINS-1:0]  pull_strong
);

  reg  [`NUM_PINS-1:0]  pin_dir;
  reg  [`NUM_PINS-1:0]  pin_out_val;
  reg  [`NUM_PINS-1:0]  group_mask;
  reg                   hs_mode;
  reg                   dtr_owns_pin;
  reg                   dtr_asserted;
  reg  [`CTRL_W-1:0]    line_ctrl;
  reg  [`EV_W-1:0]      irq_status;
  reg  [`EV_W-1:0]      irq_mask;
  reg                   ring_prev;
  reg                   live_prev;
  reg                   dsr_asserted_prev;
  reg  [`NUM_PINS-1:0]  next_pin_out;
  reg  [`DATA_W-1:0]    next_rdata;
  wire [`SYNC_W-1:0]    sync_raw;
  wire [`SYNC_W-1:0]    synced;
  wire [`NUM_PINS-1:0]  pin_in_sync;
  wire                  ri_in_sync;
  wire                  cts_sync_n;
  wire                  dsr_sync_n;
  wire                  rx_sync;
  wire                  ring_now;
  wire                  dsr_asserted;
  wire [`EV_W-1:0]      events;
  wire [`EV_W-1:0]      w1c;
  wire                  wr_hs_mode;
  wire                  wr_dtr_sel;
  wire                  wr_dtr_level;
  wire                  wr_pin_dir;
  wire                  wr_pin_out;
  wire                  wr_pull_up;
  wire                  wr_pull_strong;
  wire                  wr_group_mask;
  wire                  wr_group_data;
  wire                  wr_line_ctrl;
  wire                  wr_irq_status;
  wire                  wr_irq_mask;

  // Pin levels and the far-side handshakes arrive asynchronously, so all pass two flops.
  assign sync_raw = {serial_rx_line, dsr_n, cts_n, incoming_call_line_in, programmable_pin_in};

  line_sync u_sync (
    .clk         (clk),
    .reset_n     (reset_n),
    .async_in    (sync_raw),
    .reset_value ({`SYNC_W{`LINE_HIGH}}),
    .sync_out    (synced)
  );

  assign pin_in_sync   = synced[`NUM_PINS-1:0];
  assign ri_in_sync    = synced[`NUM_PINS];
  assign cts_sync_n    = synced[`NUM_PINS+1];
  assign dsr_sync_n    = synced[`NUM_PINS+2];
  assign rx_sync       = synced[`NUM_PINS+3];
  assign serial_rx_bit = rx_sync;
  assign tx_allowed    = ~cts_sync_n;
  assign dsr_asserted  = ~dsr_sync_n;

  // A remote setting up a call that is not yet live counts as ringing.
  assign ring_now = remote_setup & ~link_live;

  assign events[`EV_RING_START] = ring_now & ~ring_prev;
  assign events[`EV_LINK_UP]    = link_live & ~live_prev;
  assign events[`EV_LINK_DOWN]  = ~link_live & live_prev;
  assign events[`EV_DSR_DROP]   = hs_mode & link_live &
                                  dsr_asserted_prev & ~dsr_asserted;

  // One strobe per writable index keeps each register process small.
  assign wr_hs_mode     = reg_write && (reg_addr == `REG_HS_MODE);
  assign wr_dtr_sel     = reg_write && (reg_addr == `REG_DTR_SEL);
  assign wr_dtr_level   = reg_write && (reg_addr == `REG_DTR_LEVEL);
  assign wr_pin_dir     = reg_write && (reg_addr == `REG_PIN_DIR);
  assign wr_pin_out     = reg_write && (reg_addr == `REG_PIN_OUT);
  assign wr_pull_up     = reg_write && (reg_addr == `REG_PULL_UP);
  assign wr_pull_strong = reg_write && (reg_addr == `REG_PULL_STRONG);
  assign wr_group_mask  = reg_write && (reg_addr == `REG_GROUP_MASK);
  assign wr_group_data  = reg_write && (reg_addr == `REG_GROUP_DATA);
  assign wr_line_ctrl   = reg_write && (reg_addr == `REG_LINE_CTRL);
  assign wr_irq_status  = reg_write && (reg_addr == `REG_IRQ_STATUS);
  assign wr_irq_mask    = reg_write && (reg_addr == `REG_IRQ_MASK);

  assign w1c = wr_irq_status ? reg_wdata[`EV_W-1:0] : {`EV_W{1'b0}};
  assign irq = |(irq_status & irq_mask);

  // Group writes touch only the masked pins, so several outputs change on one edge.
  always @* begin
    next_pin_out = pin_out_val;
    if (wr_pin_out) begin
      next_pin_out = reg_wdata[`NUM_PINS-1:0];
    end else if (wr_group_data) begin
      next_pin_out = (pin_out_val & ~group_mask) |
                     (reg_wdata[`NUM_PINS-1:0] & group_mask);
    end
  end

  always @* begin
    next_rdata = {`DATA_W{1'b0}};
    case (reg_addr)
      `REG_HS_MODE:     next_rdata[0] = hs_mode;
      `REG_DTR_SEL:     next_rdata[0] = dtr_owns_pin;
      `REG_DTR_LEVEL:   next_rdata[0] = dtr_asserted;
      `REG_PIN_DIR:     next_rdata[`NUM_PINS-1:0] = pin_dir;
      `REG_PIN_OUT:     next_rdata[`NUM_PINS-1:0] = pin_out_val;
      `REG_PIN_IN:      next_rdata[`NUM_PINS-1:0] = pin_in_sync;
      `REG_PULL_UP:     next_rdata[`NUM_PINS-1:0] = pull_up_select;
      `REG_PULL_STRONG: next_rdata[`NUM_PINS-1:0] = pull_strong;
      `REG_GROUP_MASK:  next_rdata[`NUM_PINS-1:0] = group_mask;
      `REG_GROUP_DATA:  next_rdata[`NUM_PINS-1:0] = pin_in_sync & group_mask;
      `REG_ADC_RESULT:  next_rdata = adc_result;
      `REG_LINE_CTRL:   next_rdata[`CTRL_W-1:0] = line_ctrl;
      `REG_LINE_STAT:   next_rdata[4:0] = {dsr_asserted, ~cts_sync_n, ri_in_sync,
                                           link_live, ring_now};
      `REG_IRQ_STATUS:  next_rdata[`EV_W-1:0] = irq_status;
      `REG_IRQ_MASK:    next_rdata[`EV_W-1:0] = irq_mask;
      default:          next_rdata = {`DATA_W{1'b0}};
    endcase
  end

  // One process per register; reset leaves every pin an input with a weak pull-down.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_mode <= 1'b0;
    end else if (wr_hs_mode) begin
      hs_mode <= reg_wdata[0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dtr_owns_pin <= 1'b0;
    end else if (wr_dtr_sel) begin
      dtr_owns_pin <= reg_wdata[0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dtr_asserted <= 1'b0;
    end else if (wr_dtr_level) begin
      dtr_asserted <= reg_wdata[0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_dir <= `PINS_RESET;
    end else if (wr_pin_dir) begin
      pin_dir <= reg_wdata[`NUM_PINS-1:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_val <= `PINS_RESET;
    end else begin
      pin_out_val <= next_pin_out;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pull_up_select <= `PINS_RESET;
    end else if (wr_pull_up) begin
      pull_up_select <= reg_wdata[`NUM_PINS-1:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pull_strong <= `PINS_RESET;
    end else if (wr_pull_strong) begin
      pull_strong <= reg_wdata[`NUM_PINS-1:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      group_mask <= `PINS_RESET;
    end else if (wr_group_mask) begin
      group_mask <= reg_wdata[`NUM_PINS-1:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_ctrl <= {`CTRL_W{1'b0}};
    end else if (wr_line_ctrl) begin
      line_ctrl <= reg_wdata[`CTRL_W-1:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask <= {`EV_W{1'b0}};
    end else if (wr_irq_mask) begin
      irq_mask <= reg_wdata[`EV_W-1:0];
    end
  end

  // Read data stand for one cycle only, so an idle bus always shows zero.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= {`DATA_W{1'b0}};
    end else begin
      reg_rdata <= reg_read ? next_rdata : {`DATA_W{1'b0}};
    end
  end

  // Event edges and sticky status; a new event wins over a clear in the same cycle.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ring_prev           <= 1'b0;
      live_prev           <= 1'b0;
      dsr_asserted_prev   <= 1'b0;
      irq_status          <= {`EV_W{1'b0}};
      drop_or_command_req <= 1'b0;
    end else begin
      ring_prev           <= ring_now;
      live_prev           <= link_live;
      dsr_asserted_prev   <= dsr_asserted;
      irq_status          <= (irq_status & ~w1c) | events;
      drop_or_command_req <= events[`EV_DSR_DROP];
    end
  end

  // Handshake and data-line outputs are registered and come out of reset high.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_tx_line         <= `LINE_HIGH;
      rts_n                  <= `LINE_HIGH;
      incoming_call_line_out <= `LINE_HIGH;
      incoming_call_line_oe  <= 1'b1;
      connection_live_line   <= `LINE_HIGH;
    end else begin
      serial_tx_line         <= serial_tx_active ? serial_tx_bit : `LINE_HIGH;
      rts_n                  <= ~rx_has_room;
      incoming_call_line_out <= ~ring_now;
      incoming_call_line_oe  <= ~line_ctrl[`CTRL_RI_INPUT];
      connection_live_line   <= ~link_live;
    end
  end

  // Per-pin output stage. Pin 0 yields to terminal-ready and pin 6 to the audio clock.
  // The audio clock is resampled here, so it is only usable well below half the clock rate.
  genvar i;
  generate
    for (i = 0; i < `NUM_PINS; i = i + 1) begin : g_pin
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          programmable_pin_out[i] <= 1'b0;
          programmable_pin_oe[i]  <= 1'b0;
        end else if (i == `PIN_DTR && dtr_owns_pin) begin
          programmable_pin_out[i] <= ~dtr_asserted;
          programmable_pin_oe[i]  <= 1'b1;
        end else if (i == `PIN_AUDIO && line_ctrl[`CTRL_AUDIO_SEL]) begin
          programmable_pin_out[i] <= audio_slave_clk_src;
          programmable_pin_oe[i]  <= 1'b1;
        end else begin
          programmable_pin_out[i] <= pin_out_val[i];
          programmable_pin_oe[i]  <= pin_dir[i];
        end
      end
    end
  endgenerate

endmodule // modem_lines_and_gpio

//--- test/host_model.sv
// Host side of the serial port: handshake inputs, shared pin levels and a data echo.
// Assumes the bench steers it through keep_link, allow_send, ri_drive and host pin drive.
`timescale 1ns/10ps
module host_model (
  input  wire logic       keep_link,
  input  wire logic       allow_send,
  input  wire logic       ri_drive,
  input  wire logic [6:0] host_en,
  input  wire logic [6:0] host_val,
  input  wire logic       serial_tx_line,
  input  wire logic       incoming_call_line_out,
  input  wire logic       incoming_call_line_oe,
  input  wire logic [6:0] programmable_pin_out,
  input  wire logic [6:0] programmable_pin_oe,
  input  wire logic [6:0] pull_up_select,
  output wire logic       dsr_n,
  output wire logic       cts_n,
  output wire logic       serial_rx_line,
  output wire logic       incoming_call_line_in,
  output wire logic [6:0] programmable_pin_in
);
  assign dsr_n = !keep_link;
  assign cts_n = !allow_send;
  // Echoing the transmit line keeps receive idle high between characters.
  assign serial_rx_line = serial_tx_line;
  assign incoming_call_line_in = incoming_call_line_oe ? incoming_call_line_out : ri_drive;
  // A pin nobody drives settles to the pull level, so input mode shows the pull choice.
  assign programmable_pin_in = (programmable_pin_oe & programmable_pin_out) |
    (~programmable_pin_oe & ((host_en & host_val) | (~host_en & pull_up_select)));
endmodule // host_model

//--- test/modem_lines_and_gpio_chk.sv
// Checker on the top-level ports of the modem line and pin block.
// Assumes one clock domain and the defines header on the include path.
`timescale 1ns/10ps
`include "modem_lines_defines.vh"
module modem_lines_chk (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic [`ADDR_W-1:0]   reg_addr,
  input wire logic                 reg_write,
  input wire logic                 reg_read,
  input wire logic [`DATA_W-1:0]   reg_rdata,
  input wire logic [`DATA_W-1:0]   adc_result,
  input wire logic                 serial_tx_bit,
  input wire logic                 serial_tx_active,
  input wire logic                 serial_tx_line,
  input wire logic                 rx_has_room,
  input wire logic                 rts_n,
  input wire logic                 remote_setup,
  input wire logic                 link_live,
  input wire logic                 incoming_call_line_out,
  input wire logic                 incoming_call_line_oe,
  input wire logic                 connection_live_line,
  input wire logic                 drop_or_command_req,
  input wire logic [`NUM_PINS-1:0] pull_up_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // The past values are only trusted from the third edge after reset release.
  reg [1:0] up;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) up <= 2'h0;
    else if (!up[1]) up <= up + 2'h1;
  end
  property p_tx_line;
    up[1] |-> serial_tx_line == ($past(serial_tx_active) ? $past(serial_tx_bit) : 1'b1);
  endproperty
  a_tx_line: assert property (p_tx_line) else $error("tx line wrong");
  property p_rts;
    up[1] |-> rts_n == !$past(rx_has_room);
  endproperty
  a_rts: assert property (p_rts) else $error("rts wrong");
  property p_live;
    up[1] |-> connection_live_line == !$past(link_live);
  endproperty
  a_live: assert property (p_live) else $error("live line wrong");
  property p_ring;
    up[1] && incoming_call_line_oe |->
      incoming_call_line_out == !$past(remote_setup && !link_live);
  endproperty
  a_ring: assert property (p_ring) else $error("ring line wrong");
  property p_rdata_idle;
    up[1] && !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
  property p_adc;
    reg_read && reg_addr == `REG_ADC_RESULT |=> reg_rdata == $past(adc_result);
  endproperty
  a_adc: assert property (p_adc) else $error("adc read wrong");
  property p_pulse;
    drop_or_command_req |=> !drop_or_command_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("drop pulse too long");
  property p_pull;
    up[1] && !$past(reg_write) |-> $stable(pull_up_select);
  endproperty
  a_pull: assert property (p_pull) else $error("pull changed unasked");
endmodule // modem_lines_chk
bind modem_lines_and_gpio modem_lines_chk u_chk (.*);

//--- test/modem_lines_and_gpio_tb.sv
// Bench for the modem line and pin block, with a host model on the pins.
// Assumes the defines header on the include path and a 100 MHz clock.
`timescale 1ns/10ps
`include "modem_lines_defines.vh"
module modem_lines_and_gpio_tb;
  logic clk, reset_n, reg_write, reg_read, irq, serial_tx_bit, serial_tx_active, serial_tx_line;
  logic serial_rx_line, serial_rx_bit, rx_has_room, rts_n, cts_n, tx_allowed, dsr_n, link_live;
  logic drop_or_command_req, remote_setup, incoming_call_line_in, incoming_call_line_out;
  logic incoming_call_line_oe, connection_live_line, audio_slave_clk_src;
  logic keep_link, allow_send, ri_drive;
  logic [`ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, adc_result;
  logic [6:0] programmable_pin_in, programmable_pin_out, programmable_pin_oe, pull_up_select;
  logic [6:0] pull_strong, host_en, host_val;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
  modem_lines_and_gpio dut (.*);
  host_model host (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task give_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input [`ADDR_W-1:0] a, input [7:0] d);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task rd(input [`ADDR_W-1:0] a, input [7:0] e);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task do_reset;
    reset_n <= 1'b0;
    tick(2);
    `CHK({rts_n, connection_live_line, incoming_call_line_out, incoming_call_line_oe}, 4'hF)
    `CHK({programmable_pin_oe, programmable_pin_out, pull_up_select, pull_strong}, 28'h0)
    `CHK({irq, drop_or_command_req, serial_tx_line, reg_rdata}, 11'h100)
    reset_n <= 1'b1;
    tick(3);
  endtask
  task wait_pulse(input int e);
    int k;
    k = 0;
    repeat (8) begin
      tick(1);
      k += (drop_or_command_req === 1'b1);
    end
    `CHK(k, e)
  endtask
  initial begin
    {reg_write, reg_read, serial_tx_bit, serial_tx_active, rx_has_room, remote_setup} = 6'h0;
    {link_live, audio_slave_clk_src, allow_send, ri_drive, reset_n, keep_link} = 6'h1;
    {reg_addr, reg_wdata, adc_result, host_en, host_val} = {10'h000, 8'h00, 8'hA5, 14'h0};
    do_reset();
    wr(`REG_PIN_DIR, 8'h7F);
    wr(`REG_PIN_OUT, 8'h55);
    tick(1);
    `CHK({programmable_pin_oe, programmable_pin_out}, 14'h3FD5)
    tick(3);
    rd(`REG_PIN_IN, 8'h55);
    wr(`REG_GROUP_MASK, 8'h0F);
    wr(`REG_GROUP_DATA, 8'h0A);
    tick(3);
    `CHK(programmable_pin_out, 7'h5A)
    rd(`REG_GROUP_DATA, 8'h0A);
    wr(`REG_PULL_UP, 8'h0F);
    wr(`REG_PULL_STRONG, 8'h30);
    wr(`REG_PIN_DIR, 8'h00);
    tick(4);
    `CHK({pull_up_select, pull_strong, programmable_pin_oe}, 21'h03D800)
    rd(`REG_PIN_IN, 8'h0F);
    {host_en, host_val} <= {7'h7F, 7'h33};
    tick(3);
    rd(`REG_PIN_IN, 8'h33);
    rd(10'h3FF, 8'h00);
    rd(`REG_ADC_RESULT, 8'hA5);
    wr(`REG_DTR_SEL, 8'h01);
    wr(`REG_DTR_LEVEL, 8'h01);
    tick(1);
    `CHK({programmable_pin_oe[0], programmable_pin_out[0]}, 2'b10)
    wr(`REG_LINE_CTRL, 8'h02);
    audio_slave_clk_src <= 1'b1;
    tick(2);
    `CHK({programmable_pin_oe[6], programmable_pin_out[6]}, 2'b11)
    wr(`REG_LINE_CTRL, 8'h01);
    tick(4);
    `CHK(incoming_call_line_oe, 1'b0)
    rd(`REG_LINE_STAT, 8'h10);
    ri_drive <= 1'b1;
    tick(3);
    rd(`REG_LINE_STAT, 8'h14);
    wr(`REG_LINE_CTRL, 8'h00);
    wr(`REG_IRQ_MASK, 8'h0F);
    remote_setup <= 1'b1;
    tick(2);
    `CHK({incoming_call_line_out, irq}, 2'b01)
    link_live <= 1'b1;
    tick(2);
    `CHK({incoming_call_line_out, connection_live_line}, 2'b10)
    rd(`REG_IRQ_STATUS, 8'h03);
    wr(`REG_IRQ_STATUS, 8'h03);
    tick(1);
    `CHK(irq, 1'b0)
    wr(`REG_HS_MODE, 8'h01);
    keep_link <= 1'b0;
    wait_pulse(1);
    keep_link <= 1'b1;
    wr(`REG_HS_MODE, 8'h00);
    keep_link <= 1'b0;
    wait_pulse(0);
    rd(`REG_IRQ_STATUS, 8'h08);
    wr(`REG_IRQ_MASK, 8'h00);
    tick(1);
    `CHK(irq, 1'b0)
    {rx_has_room, allow_send, serial_tx_active, keep_link} <= 4'hF;
    tick(4);
    `CHK({rts_n, tx_allowed, serial_tx_line, serial_rx_bit}, 4'b0100)
    {rx_has_room, serial_tx_active} <= 2'b00;
    tick(4);
    `CHK({rts_n, serial_tx_line, serial_rx_bit}, 3'b111)
    do_reset();
    rd(`REG_PULL_UP, 8'h00);
    give_verdict();
  end
endmodule // modem_lines_and_gpio_tb
